// File: core/nv_write_control_and_protection.v
// Function
// - clearing selection cancels and drops latched pairs
// - page ops keep only last page address
// - operand limits per operation enforced
// - four protection bytes at test area top
// - all protections active until loaded after reset
// - set protection refused from code or test fetch
// - test area range always write rejected
// - protection bits only program one to zero
// - code access protection honours fetch source
// - test area access protection honours fetch source
// - data memory access protection honours fetch source
// - external fetch blocks all internal memory
// - bad password clears one attempt bit
// - test mode allow bypasses, cleared on first password
// - matching password clears password accepted bit
// - test area write protect, never temporarily lifted
// - data memory write protect, temporarily liftable
// - sector write protect bits guard code sectors
// - reading write protect byte restores lifted protections
// - password bytes write only, read all ones
// - memory under write reads all ones
`timescale 1ns/100ps
`default_nettype none
`include "nvwp_defs.vh"
module nv_write_control_and_protection #(
	parameter DEPTH = 16,
	parameter IDX_W = 4
) (
	input wire core_clk,
	input wire rst_n,
	input wire por_n,
	input wire [21:0] bus_addr,
	input wire [7:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	input wire [7:0] mem_rdata,
	input wire fetch_valid,
	input wire [21:0] fetch_addr,
	input wire test_mode,
	input wire arr_done,
	output reg [7:0] rd_data_r,
	output reg rd_valid_r,
	output reg access_denied_r,
	output reg write_rejected_r,
	output reg arr_valid_r,
	output reg [2:0] arr_cmd_r,
	output reg [21:0] arr_addr_r,
	output reg [7:0] arr_data_r,
	output reg code_busy_r,
	output reg data_busy_r,
	output reg op_done_r,
	output reg test_unlock_r
);
// ----------------------------------------
// states
// ----------------------------------------
localparam ST_LOAD = 3'h0;
localparam ST_IDLE = 3'h1;
localparam ST_ISSUE = 3'h2;
localparam ST_WAIT = 3'h3;
localparam ST_SELECT_SET_PROTECTION = 3'h4;
localparam ST_PWD = 3'h5;

// ----------------------------------------
// helpers
// ----------------------------------------
function [2:0] region_of;
	input [21:0] a;
	begin
		if (a <= `A_CODE_END)
			region_of = `RG_CODE;
		else if (a >= `A_TEST_BASE && a <= `A_AREA_END)
			region_of = `RG_TEST;
		else if (a >= `A_DATA_BASE && a <= `A_DATA_END)
			region_of = `RG_DATA;
		else if (a >= `A_RAM_BASE && a <= `A_RAM_END)
			region_of = `RG_RAM;
		else if (a == `A_CODE_CTRL || a == `A_DATA_CTRL)
			region_of = `RG_CTRL;
		else
			region_of = `RG_EXT;
	end
endfunction

function [1:0] sector_of;
	input [21:0] a;
	begin
		if (a < `A_SEC1)
			sector_of = 2'h0;
		else if (a < `A_SEC2)
			sector_of = 2'h1;
		else if (a < `A_SEC3)
			sector_of = 2'h2;
		else
			sector_of = 2'h3;
	end
endfunction

function onehot6;
	input [6:1] s;
	begin
		onehot6 = (s != 6'h00) && ((s & (s - 6'h01)) == 6'h00);
	end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
reg [2:0] st_r;
reg loaded_r;
reg started_r;
reg [6:1] fsel_r;
reg [6:5] dsel_r;
reg [IDX_W:0] cnt_r;
reg [IDX_W-1:0] idx_r;
reg [21:`PAGE_LSB] page_r;
reg [21:0] ea_r [0:DEPTH-1];
reg [7:0] ed_r [0:DEPTH-1];
reg [2:0] src_r;
reg [7:0] nv_ap_r;
reg [7:0] nv_wp_r;
reg [15:0] nv_pw_r;
reg [7:0] tmp_wp_r;
reg [1:0] pw_seen_r;
reg [15:0] pw_in_r;

wire [2:0] rg = region_of(bus_addr);
wire [1:0] sec = sector_of(bus_addr);
wire [21:0] cur_a = ea_r[idx_r];
wire [7:0] cur_d = ed_r[idx_r];
wire [IDX_W:0] idx_nx = {1'b0, idx_r} + 1'b1;
// test mode bypass while allowed or password accepted
wire bypass = loaded_r & test_mode & (nv_wp_r[`WP_TMA] | ~nv_wp_r[`WP_PASSWORD_ACCEPTED]);
// forced on until loaded, then stored value, write protect with temporary lifts ORed in
wire [7:0] ap_eff = bypass ? `ALL_ONES : (loaded_r ? nv_ap_r : `SELECT_SET_PROTECTION_ALL_ON);
wire [7:0] wp_eff = bypass ? `ALL_ONES : (loaded_r ? (nv_wp_r | tmp_wp_r) : `SELECT_SET_PROTECTION_ALL_ON);
wire in_select_set_protection = bus_addr >= `A_SELECT_SET_PROTECTION_BASE && bus_addr <= `A_AREA_END;
wire bad_src = src_r == `RG_CODE || src_r == `RG_TEST;
wire cw = bus_wr && bus_addr == `A_CODE_CTRL;
wire dw = bus_wr && bus_addr == `A_DATA_CTRL;
wire mem_rg = rg == `RG_CODE || rg == `RG_TEST || rg == `RG_DATA;

// ----------------------------------------
// access and write protection checks
// ----------------------------------------
reg acc_deny;
reg wprot;
always @* begin
	acc_deny = 1'b0;
	case (rg)
		`RG_CODE: acc_deny = ~ap_eff[`AP_CODE] && !bad_src;
		`RG_TEST: acc_deny = ~ap_eff[`AP_TEST] && src_r != `RG_TEST;
		`RG_DATA: acc_deny = ~ap_eff[`AP_DATA] && !bad_src && src_r != `RG_DATA;
		default: acc_deny = 1'b0;
	endcase
	if (~ap_eff[`AP_EXT] && src_r == `RG_EXT && rg != `RG_EXT && rg != `RG_CTRL)
		acc_deny = 1'b1;
end

always @* begin
	case (rg)
		`RG_CODE: wprot = ~wp_eff[sec];
		`RG_TEST: wprot = ~wp_eff[`WP_TEST] | (bus_addr <= `A_TEST_END);
		`RG_DATA: wprot = ~wp_eff[`WP_DATA];
		default: wprot = 1'b0;
	endcase
end

// ----------------------------------------
// operand limit, target and command
// ----------------------------------------
reg [IDX_W:0] lim;
reg tgt_ok;
reg [2:0] cmd;
always @* begin
	lim = `N_NONE;
	tgt_ok = 1'b0;
	cmd = `CMD_NONE;
	if (fsel_r[`C_BYTE]) begin
		lim = `N_BYTE;
		tgt_ok = rg == `RG_CODE;
		cmd = `CMD_BYTE;
	end else if (fsel_r[`C_PAGE]) begin
		lim = `N_PAGE;
		tgt_ok = rg == `RG_CODE;
		cmd = `CMD_PAGE;
	end else if (fsel_r[`C_SECT]) begin
		lim = `N_SECT;
		tgt_ok = rg == `RG_CODE;
		cmd = `CMD_SECT;
	end else if (fsel_r[`C_SELECT_SET_PROTECTION]) begin
		lim = `N_SELECT_SET_PROTECTION;
		tgt_ok = in_select_set_protection;
	end else if (fsel_r[`C_CHIP]) begin
		cmd = `CMD_CCHIP;
	end else if (dsel_r[`D_PAGE]) begin
		lim = `N_PAGE;
		tgt_ok = rg == `RG_DATA;
		cmd = `CMD_DPAGE;
	end else if (dsel_r[`D_CHIP]) begin
		cmd = `CMD_DCHIP;
	end
end

wire latch_ok = bus_wr && !started_r && tgt_ok && !acc_deny && !wprot && cnt_r < lim;
wire select_set_protection_refused = cw && !started_r && bus_wdata[`C_START] && fsel_r[`C_SELECT_SET_PROTECTION] && bad_src;
// start needs one selection already made, with operands unless chip erase
wire fstart = cw && !started_r && bus_wdata[`C_START] && onehot6(fsel_r) && !fsel_r[`C_SUSP] &&
	dsel_r == 2'h0 && (fsel_r[`C_CHIP] || cnt_r != `N_NONE) && !(fsel_r[`C_SELECT_SET_PROTECTION] && bad_src);
wire dstart = dw && !started_r && bus_wdata[`C_START] && fsel_r == 6'h00 &&
	(dsel_r[`D_PAGE] ^ dsel_r[`D_CHIP]) && (dsel_r[`D_CHIP] || cnt_r != `N_NONE);
wire suspend = cw && bus_wdata[`C_SUSP] && fsel_r[`C_SECT] && st_r == ST_WAIT;
wire chip = fsel_r[`C_CHIP] || dsel_r[`D_CHIP];

// ----------------------------------------
// operand latches
// ----------------------------------------
// pair storage, written at the running count
always @(posedge core_clk) begin
	if (latch_ok) begin
		ea_r[cnt_r[IDX_W-1:0]] <= bus_addr;
		ed_r[cnt_r[IDX_W-1:0]] <= bus_wdata;
	end
end

// ----------------------------------------
// sequencer
// ----------------------------------------
// selection, latch count, start and array command issue
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		st_r <= ST_LOAD;
		loaded_r <= 1'b0;
		started_r <= 1'b0;
		fsel_r <= 6'h00;
		dsel_r <= 2'h0;
		cnt_r <= `N_NONE;
		idx_r <= {IDX_W{1'b0}};
		page_r <= {(22-`PAGE_LSB){1'b0}};
		code_busy_r <= 1'b0;
		data_busy_r <= 1'b0;
		arr_valid_r <= 1'b0;
		arr_cmd_r <= `CMD_NONE;
		arr_addr_r <= 22'h00_0000;
		arr_data_r <= 8'h00;
		op_done_r <= 1'b0;
		write_rejected_r <= 1'b0;
		pw_seen_r <= 2'h0;
		pw_in_r <= `PW_DELIVERY;
	end else begin
		arr_valid_r <= 1'b0;
		op_done_r <= 1'b0;
		write_rejected_r <= (bus_wr && mem_rg && !latch_ok) || select_set_protection_refused;
		if (latch_ok) begin
			cnt_r <= cnt_r + 1'b1;
			page_r <= bus_addr[21:`PAGE_LSB];
		end
		case (st_r)
			ST_LOAD: begin
				loaded_r <= 1'b1;
				st_r <= ST_IDLE;
			end
			ST_IDLE: begin
				if (fstart || dstart) begin
					started_r <= 1'b1;
					code_busy_r <= fstart;
					data_busy_r <= dstart;
					idx_r <= {IDX_W{1'b0}};
					pw_seen_r <= 2'h0;
					pw_in_r <= `PW_DELIVERY;
					st_r <= fsel_r[`C_SELECT_SET_PROTECTION] ? ST_SELECT_SET_PROTECTION : ST_ISSUE;
				end else if (cw) begin
					fsel_r <= bus_wdata[6:1];
					if ((fsel_r & ~bus_wdata[6:1]) != 6'h00)
						cnt_r <= `N_NONE;
				end else if (dw) begin
					dsel_r <= bus_wdata[6:5];
					if ((dsel_r & ~bus_wdata[6:5]) != 2'h0)
						cnt_r <= `N_NONE;
				end
			end
			ST_ISSUE: begin
				arr_valid_r <= 1'b1;
				arr_cmd_r <= cmd;
				if (chip)
					arr_addr_r <= 22'h00_0000;
				else if (cmd == `CMD_PAGE || cmd == `CMD_DPAGE)
					arr_addr_r <= {page_r, cur_a[`PAGE_LSB-1:0]};
				else
					arr_addr_r <= cur_a;
				arr_data_r <= chip ? `ALL_ONES : cur_d;
				st_r <= ST_WAIT;
			end
			ST_WAIT: begin
				if (suspend) begin
					arr_valid_r <= 1'b1;
					arr_cmd_r <= `CMD_SUSP;
					st_r <= ST_PWD;
				end else if (arr_done) begin
					if (chip || idx_nx >= cnt_r)
						st_r <= ST_PWD;
					else begin
						idx_r <= idx_nx[IDX_W-1:0];
						st_r <= ST_ISSUE;
					end
				end
			end
			ST_SELECT_SET_PROTECTION: begin
				if (cur_a == `A_PW0) begin
					pw_seen_r[0] <= 1'b1;
					pw_in_r[7:0] <= cur_d;
				end
				if (cur_a == `A_PW1) begin
					pw_seen_r[1] <= 1'b1;
					pw_in_r[15:8] <= cur_d;
				end
				idx_r <= idx_nx[IDX_W-1:0];
				if (idx_nx >= cnt_r)
					st_r <= ST_PWD;
			end
			ST_PWD: begin
				st_r <= ST_IDLE;
				started_r <= 1'b0;
				fsel_r <= 6'h00;
				dsel_r <= 2'h0;
				cnt_r <= `N_NONE;
				code_busy_r <= 1'b0;
				data_busy_r <= 1'b0;
				op_done_r <= 1'b1;
			end
			default: st_r <= ST_IDLE;
		endcase
	end
end

// ----------------------------------------
// non-volatile protection bytes
// ----------------------------------------
// only power-on restores delivery value; bits only go to zero
always @(posedge core_clk or negedge por_n) begin
	if (!por_n) begin
		nv_ap_r <= `NV_DELIVERY;
		nv_wp_r <= `NV_DELIVERY;
		nv_pw_r <= `PW_DELIVERY;
	end else if (st_r == ST_SELECT_SET_PROTECTION) begin
		if (cur_a == `A_AP)
			nv_ap_r <= nv_ap_r & (cur_d | ~`AP_USER_MASK);
		if (cur_a == `A_WP)
			nv_wp_r <= nv_wp_r & (cur_d | ~`WP_USER_MASK);
	end else if (st_r == ST_PWD && pw_seen_r != 2'h0) begin
		if (nv_wp_r[`WP_TMA]) begin
			nv_pw_r <= nv_pw_r & pw_in_r;
			nv_wp_r[`WP_TMA] <= 1'b0;
		end else if (nv_wp_r[`WP_PASSWORD_ACCEPTED] && (nv_ap_r & `AP_ATT_MASK) != 8'h00) begin
			if (pw_in_r == nv_pw_r)
				nv_wp_r[`WP_PASSWORD_ACCEPTED] <= 1'b0;
			else if (nv_ap_r[`AP_ATT2])
				nv_ap_r[`AP_ATT2] <= 1'b0;
			else if (nv_ap_r[`AP_ATT1])
				nv_ap_r[`AP_ATT1] <= 1'b0;
			else
				nv_ap_r[`AP_ATT0] <= 1'b0;
		end
	end
end

// ----------------------------------------
// read path, fetch source, temporary unprotection
// ----------------------------------------
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		rd_data_r <= `ALL_ONES;
		rd_valid_r <= 1'b0;
		access_denied_r <= 1'b0;
		src_r <= `RG_EXT;
		tmp_wp_r <= 8'h00;
		test_unlock_r <= 1'b0;
	end else begin
		rd_valid_r <= bus_rd;
		access_denied_r <= (bus_rd || bus_wr) && acc_deny;
		test_unlock_r <= bypass;
		if (fetch_valid)
			src_r <= region_of(fetch_addr);
		if (st_r == ST_SELECT_SET_PROTECTION && cur_a == `A_WP)
			tmp_wp_r <= cur_d & `WP_TMP_MASK;
		else if (bus_rd && bus_addr == `A_WP && !acc_deny)
			tmp_wp_r <= 8'h00;
		if (bus_rd) begin
			if (acc_deny)
				rd_data_r <= `ALL_ONES;
			else if (bus_addr == `A_CODE_CTRL)
				rd_data_r <= {started_r & code_busy_r, fsel_r, code_busy_r};
			else if (bus_addr == `A_DATA_CTRL)
				rd_data_r <= {started_r & data_busy_r, dsel_r, `D_PAD, data_busy_r};
			else if (bus_addr == `A_AP)
				rd_data_r <= nv_ap_r;
			else if (bus_addr == `A_WP)
				rd_data_r <= nv_wp_r;
			else if (bus_addr == `A_PW0 || bus_addr == `A_PW1)
				rd_data_r <= `ALL_ONES;
			else if ((rg == `RG_CODE && code_busy_r) || (rg == `RG_DATA && data_busy_r))
				rd_data_r <= `ALL_ONES;
			else
				rd_data_r <= mem_rdata;
		end
	end
end

endmodule
`default_nettype wire

// File: core/nvwp_defs.vh
`ifndef NVWP_DEFS_VH
`define NVWP_DEFS_VH
// ----------------------------------------
// address map
// ----------------------------------------
`define A_CODE_END 22'h03_FFFF
`define A_SEC1 22'h00_2000
`define A_SEC2 22'h00_4000
`define A_SEC3 22'h01_0000
`define A_RAM_BASE 22'h20_0000
`define A_RAM_END 22'h20_FFFF
`define A_DATA_BASE 22'h22_0000
`define A_DATA_END 22'h22_03FF
`define A_CODE_CTRL 22'h22_4000
`define A_DATA_CTRL 22'h22_4001
`define A_TEST_BASE 22'h23_0000
`define A_TEST_END 22'h23_1F7F
`define A_SELECT_SET_PROTECTION_BASE 22'h23_1FFC
`define A_AP 22'h23_1FFC
`define A_WP 22'h23_1FFD
`define A_PW0 22'h23_1FFE
`define A_PW1 22'h23_1FFF
`define A_AREA_END 22'h23_1FFF
`define PAGE_LSB 4
// ----------------------------------------
// regions of an address
// ----------------------------------------
`define RG_CODE 3'h0
`define RG_TEST 3'h1
`define RG_DATA 3'h2
`define RG_RAM 3'h3
`define RG_EXT 3'h4
`define RG_CTRL 3'h5
// ----------------------------------------
// protection byte fields and values
// ----------------------------------------
`define AP_CODE 6
`define AP_TEST 5
`define AP_DATA 4
`define AP_EXT 3
`define AP_ATT2 2
`define AP_ATT1 1
`define AP_ATT0 0
`define AP_ATT_MASK 8'h07
`define AP_USER_MASK 8'h78
`define WP_TMA 7
`define WP_PASSWORD_ACCEPTED 6
`define WP_TEST 5
`define WP_DATA 4
`define WP_USER_MASK 8'h3F
`define WP_TMP_MASK 8'h1F
`define NV_DELIVERY 8'hFF
`define PW_DELIVERY 16'hFFFF
`define SELECT_SET_PROTECTION_ALL_ON 8'h00
`define ALL_ONES 8'hFF
// ----------------------------------------
// control register fields
// ----------------------------------------
`define C_START 7
`define C_BYTE 6
`define C_PAGE 5
`define C_SELECT_SET_PROTECTION 4
`define C_SECT 3
`define C_SUSP 2
`define C_CHIP 1
`define C_BUSY 0
`define D_PAGE 6
`define D_CHIP 5
`define D_PAD 4'h0
// ----------------------------------------
// operand limits and array commands
// ----------------------------------------
`define N_BYTE 5'h01
`define N_PAGE 5'h10
`define N_SECT 5'h04
`define N_SELECT_SET_PROTECTION 5'h04
`define N_NONE 5'h00
`define CMD_NONE 3'h0
`define CMD_BYTE 3'h1
`define CMD_PAGE 3'h2
`define CMD_SECT 3'h3
`define CMD_SUSP 3'h4
`define CMD_CCHIP 3'h5
`define CMD_DPAGE 3'h6
`define CMD_DCHIP 3'h7
`endif

// File: verification/nv_write_control_and_protection_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "nvwp_defs.vh"
module nvwp_chk #(
	parameter DEPTH = 16,
	parameter IDX_W = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [21:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic test_mode,
	input wire logic [7:0] rd_data_r,
	input wire logic rd_valid_r,
	input wire logic access_denied_r,
	input wire logic write_rejected_r,
	input wire logic arr_valid_r,
	input wire logic code_busy_r,
	input wire logic data_busy_r,
	input wire logic op_done_r,
	input wire logic test_unlock_r
);
	// ----------------------------------------
	// answer timing and protection checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (bus_rd |=> rd_valid_r)
		else $error("read not answered");
	a_pw_ones: assert property (bus_rd && (bus_addr == `A_PW0 || bus_addr == `A_PW1)
		|=> rd_data_r == `ALL_ONES)
		else $error("password byte readable");
	a_test_wr_rej: assert property (bus_wr && bus_addr >= `A_TEST_BASE && bus_addr <= `A_TEST_END
		|=> write_rejected_r || access_denied_r)
		else $error("test area write taken");
	a_busy_ones: assert property (code_busy_r && bus_rd && bus_addr <= `A_CODE_END
		|=> rd_data_r == `ALL_ONES)
		else $error("busy code memory readable");
	a_denied_ones: assert property (access_denied_r && rd_valid_r |-> rd_data_r == `ALL_ONES)
		else $error("denied read leaks data");
	a_arr_busy: assert property (arr_valid_r |-> code_busy_r || data_busy_r)
		else $error("array command while idle");
	a_done_idle: assert property (op_done_r |-> !code_busy_r && !data_busy_r)
		else $error("done while busy");
	a_arr_single: assert property (arr_valid_r |=> !arr_valid_r)
		else $error("array command repeated");
	a_unlock_tm: assert property (test_unlock_r |-> $past(test_mode))
		else $error("unlock without test mode");
	a_rej_cause: assert property (write_rejected_r |-> $past(bus_wr))
		else $error("reject without write");
	a_reset_lock: assert property ($rose(rst_n) |-> !test_unlock_r)
		else $error("unlocked at reset release");
endmodule
bind nv_write_control_and_protection nvwp_chk #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_chk (
	.core_clk, .rst_n, .bus_addr, .bus_wr, .bus_rd, .test_mode, .rd_data_r, .rd_valid_r,
	.access_denied_r, .write_rejected_r, .arr_valid_r, .code_busy_r, .data_busy_r,
	.op_done_r, .test_unlock_r
);
`default_nettype wire

// File: verification/tb_nv_write_control_and_protection.sv
`timescale 1ns/100ps
`default_nettype none
`include "nvwp_defs.vh"
module tb_nv_write_control_and_protection;
	// ----------------------------------------
	// stimulus, notes and monitor
	// ----------------------------------------
	logic core_clk = 0, rst_n = 0, por_n = 0;
	logic bus_wr = 0, bus_rd = 0, fetch_valid = 0, test_mode = 0, arr_done = 0;
	logic [21:0] bus_addr = 0, fetch_addr = 0, arr_addr_r;
	logic [7:0] bus_wdata = 0, mem_rdata = 0, rd_data_r, arr_data_r;
	logic [2:0] arr_cmd_r;
	logic rd_valid_r, access_denied_r, write_rejected_r, arr_valid_r;
	logic code_busy_r, data_busy_r, op_done_r, test_unlock_r;
	logic [35:0] q[$];
	int err_count = 0, checks = 0, seed = 30518;

	nv_write_control_and_protection dut (
		.core_clk, .rst_n, .por_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .mem_rdata,
		.fetch_valid, .fetch_addr, .test_mode, .arr_done, .rd_data_r, .rd_valid_r,
		.access_denied_r, .write_rejected_r, .arr_valid_r, .arr_cmd_r, .arr_addr_r,
		.arr_data_r, .code_busy_r, .data_busy_r, .op_done_r, .test_unlock_r
	);

	// free running core clock
	always #5 core_clk = ~core_clk;

	task chk(input logic [35:0] seen, input logic [35:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task results;
		$display("err_count %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task nt(input logic [2:0] k, input logic [32:0] v);
		q.push_back({k, v});
	endtask

	task pop(input logic [35:0] s);
		chk(s, q.size() != 0 ? q.pop_front() : 36'hx);
	endtask

	// each result pulse takes the oldest note
	always @(negedge core_clk) begin
		if (rd_valid_r === 1) pop({3'h1, 25'h0, rd_data_r});
		if (access_denied_r === 1) pop({3'h2, 33'h0});
		if (write_rejected_r === 1) pop({3'h3, 33'h0});
		if (arr_valid_r === 1) pop({3'h4, arr_cmd_r, arr_addr_r, arr_data_r});
		if (op_done_r === 1) pop({3'h5, 33'h0});
	end

	task wr(input logic [21:0] a, input logic [7:0] d);
		@(negedge core_clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1;
		@(negedge core_clk);
		bus_wr = 0;
	endtask

	task rd(input logic [21:0] a, input logic [7:0] e, input logic m, input logic den);
		@(negedge core_clk);
		mem_rdata = 8'($random(seed));
		nt(3'h1, {25'h0, m ? mem_rdata : e});
		if (den) nt(3'h2, 0);
		bus_addr = a;
		bus_rd = 1;
		@(negedge core_clk);
		bus_rd = 0;
	endtask

	task fe(input logic [21:0] a);
		@(negedge core_clk);
		fetch_addr = a;
		fetch_valid = 1;
		@(negedge core_clk);
		fetch_valid = 0;
	endtask

	task settle;
		int i;
		for (i = 0; i < 60 && (code_busy_r !== 0 || data_busy_r !== 0 || q.size() != 0); i++)
			@(negedge core_clk);
		if (i == 60) begin
			err_count++;
			results;
		end
	endtask

	// answers each array command, optionally reading the busy memory first
	task serve(input int n, input logic probe);
		int i;
		repeat (n) begin
			for (i = 0; i < 40 && arr_valid_r !== 1; i++)
				@(negedge core_clk);
			if (i == 40) begin
				err_count++;
				results;
			end
			if (probe) rd(22'h00_0010, 8'hFF, 0, 0);
			arr_done = 1;
			@(negedge core_clk);
			arr_done = 0;
		end
	endtask

	task run(input logic [21:0] c, input logic [7:0] s, input logic [2:0] k, input logic [21:0] a,
		input logic [7:0] d);
		wr(c, s);
		if (k != 3'h5 && k != 3'h7) wr(a, d);
		nt(3'h4, {k, a, d});
		nt(3'h5, 0);
		wr(c, s | 8'h80);
		serve(1, 0);
		settle;
	endtask

	// byte program, refused when the sector is guarded
	task bp(input logic [21:0] a, input logic ok);
		logic [7:0] d;
		d = 8'($random(seed));
		wr(`A_CODE_CTRL, 8'h40);
		if (!ok) nt(3'h3, 0);
		wr(a, d);
		if (ok) begin
			nt(3'h3, 0);
			wr(a + 22'h1, d);
			nt(3'h4, {3'h1, a, d});
			wr(`A_CODE_CTRL, 8'hC0);
			serve(1, 1);
			nt(3'h5, 0);
		end else begin
			wr(`A_CODE_CTRL, 8'h00);
		end
		settle;
	endtask

	task sp(input logic [21:0] a0, input logic [7:0] d0, input logic [21:0] a1, input logic [7:0] d1);
		wr(`A_CODE_CTRL, 8'h10);
		wr(a0, d0);
		wr(a1, d1);
		nt(3'h5, 0);
		wr(`A_CODE_CTRL, 8'h90);
		settle;
	endtask

	// main sequence
	initial begin
		repeat (12) @(negedge core_clk);
		rst_n = 1;
		por_n = 1;
		repeat (2) @(negedge core_clk);
		fe(`A_RAM_BASE);
		rd(`A_AP, 8'hFF, 0, 0);
		rd(`A_WP, 8'hFF, 0, 0);
		bp(22'h01_0005, 1);
		wr(`A_CODE_CTRL, 8'h20);
		wr(22'h00_0123, 8'h11);
		wr(22'h00_0245, 8'h22);
		nt(3'h4, {3'h2, 22'h00_0243, 8'h11});
		nt(3'h4, {3'h2, 22'h00_0245, 8'h22});
		nt(3'h5, 0);
		wr(`A_CODE_CTRL, 8'hA0);
		serve(2, 0);
		settle;
		wr(`A_CODE_CTRL, 8'h20);
		wr(22'h00_0300, 8'h33);
		wr(`A_CODE_CTRL, 8'h00);
		run(`A_CODE_CTRL, 8'h20, 3'h2, 22'h00_0301, 8'h44);
		run(`A_DATA_CTRL, 8'h40, 3'h6, 22'h22_0011, 8'h55);
		run(`A_CODE_CTRL, 8'h02, 3'h5, 22'h0, 8'hFF);
		run(`A_DATA_CTRL, 8'h20, 3'h7, 22'h0, 8'hFF);
		// sector erase, then suspend while it waits
		wr(`A_CODE_CTRL, 8'h08);
		wr(22'h00_4000, 8'h00);
		nt(3'h4, {3'h3, 22'h00_4000, 8'h00});
		nt(3'h4, {3'h4, 22'h00_4000, 8'h00});
		nt(3'h5, 0);
		wr(`A_CODE_CTRL, 8'h88);
		@(negedge core_clk);
		wr(`A_CODE_CTRL, 8'h0C);
		settle;
		wr(`A_CODE_CTRL, 8'h20);
		nt(3'h3, 0);
		wr(22'h23_0010, 8'h00);
		wr(`A_CODE_CTRL, 8'h00);
		fe(22'h00_1000);
		wr(`A_CODE_CTRL, 8'h10);
		wr(`A_WP, 8'hFF);
		nt(3'h3, 0);
		wr(`A_CODE_CTRL, 8'h90);
		wr(`A_CODE_CTRL, 8'h00);
		fe(`A_RAM_BASE);
		sp(`A_PW0, 8'h12, `A_PW1, 8'h34);
		rd(`A_WP, 8'h7F, 0, 0);
		rd(`A_PW1, 8'hFF, 0, 0);
		sp(`A_PW0, 8'h12, `A_PW1, 8'h35);
		rd(`A_AP, 8'hFB, 0, 0);
		sp(`A_PW0, 8'h12, `A_PW1, 8'h34);
		rd(`A_WP, 8'h3F, 0, 0);
		sp(`A_WP, 8'h3E, `A_WP, 8'h3E);
		rd(`A_WP, 8'h3E, 0, 0);
		bp(22'h00_0050, 0);
		sp(`A_WP, 8'h3F, `A_WP, 8'h3F);
		bp(22'h00_0050, 1);
		rd(`A_WP, 8'h3E, 0, 0);
		bp(22'h00_0050, 0);
		sp(`A_AP, 8'hB7, `A_AP, 8'hB7);
		rd(22'h00_0100, 8'hFF, 0, 1);
		fe(22'h00_0200);
		rd(22'h00_0100, 8'h00, 1, 0);
		fe(22'h30_0000);
		rd(22'h20_0010, 8'hFF, 0, 1);
		settle;
		rst_n = 0;
		repeat (3) @(negedge core_clk);
		rst_n = 1;
		repeat (2) @(negedge core_clk);
		fe(`A_RAM_BASE);
		sp(`A_AP, 8'hFF, `A_WP, 8'hFF);
		rd(`A_AP, 8'hB3, 0, 0);
		rd(`A_WP, 8'h3E, 0, 0);
		sp(`A_AP, 8'hEF, `A_AP, 8'hEF);
		rd(22'h22_0010, 8'hFF, 0, 1);
		fe(22'h22_0000);
		rd(22'h22_0010, 8'h00, 1, 0);
		// test area write protect, second pair tries to lift it
		sp(`A_WP, 8'h1E, `A_WP, 8'h3F);
		wr(`A_CODE_CTRL, 8'h10);
		nt(3'h3, 0);
		wr(`A_AP, 8'hFF);
		wr(`A_CODE_CTRL, 8'h00);
		test_mode = 1;
		repeat (3) @(negedge core_clk);
		chk({35'h0, test_unlock_r}, 36'h1);
		settle;
		results;
	end
endmodule
`default_nettype wire
